// ==== wiegand_tx_pkg.sv ====
// Package for the two-line pulse card data transmitter.
// Assumes a single 10 MHz reference clock and open-drain link lines.
package wiegand_tx_pkg;

  // Reference clock rate in MHz.
  localparam int CLK_MHZ       = 10;
  // Strobe lead and trail gap in microseconds.
  localparam int STROBE_GAP_US = 10000;
  // Low time of one bit pulse in microseconds.
  localparam int PULSE_US      = 100;
  // Start-to-start bit period in microseconds.
  localparam int PERIOD_US     = 1000;

  // Derived cycle counts at the reference clock.
  localparam int STROBE_CYCLES_DEF = STROBE_GAP_US * CLK_MHZ;
  localparam int PULSE_CYCLES      = PULSE_US * CLK_MHZ;
  localparam int PERIOD_CYCLES_DEF = PERIOD_US * CLK_MHZ;

  // Widths of the frame shifter and the counters.
  localparam int CNT_W     = 17;
  localparam int LEFT_W    = 6;
  localparam int FRAME_W   = 33;
  localparam int W26_LEN   = 26;
  localparam int W33_LEN   = 33;
  localparam int W26_FAC_W = 8;
  localparam int ID_W      = 16;
  // Pad that left-justifies a short frame in the shifter.
  localparam int W26_PAD   = FRAME_W - W26_LEN;

  // Selected output protocol.
  typedef enum logic [1:0] {PROTO_NONE, PROTO_W26, PROTO_W33} proto_t;

  // Configuration set by the surrounding controller.
  typedef struct packed {
    proto_t proto;
    logic   strobe_en;
  } cfg_t;

  // Identification data of one presented medium.
  typedef struct packed {
    logic [ID_W-1:0] facility;
    logic [ID_W-1:0] user;
  } card_t;

  // One bit for each link line.
  typedef struct packed {
    logic zero_line;
    logic one_bit_line;
    logic card_load_strobe;
  } link_t;

endpackage : wiegand_tx_pkg

// ==== wiegand_card_data_transmitter.sv ====
// Transmitter that frames a medium's facility and user number into a
// 26-bit or 33-bit two-line pulse frame, with an optional strobe.
// Assumes card data and configuration come from logic on ref_clk and
// that the link lines are open drain with external pull-ups.
`timescale 1ns/10ps

module wiegand_card_data_transmitter
  import wiegand_tx_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_CYCLES_DEF,
  parameter int PERIOD_CYCLES = PERIOD_CYCLES_DEF
)(
  // Clock and reset.
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // Configuration.
  input  wire cfg_t  cfg,
  // Card data request and acceptance.
  input  wire logic  card_valid,
  input  wire card_t card,
  output logic       card_ready,
  // Open-drain link lines.
  input  wire link_t link_in,
  output link_t      link_out,
  output link_t      link_oe
);

  // Gap between the end of one pulse and the start of the next.
  localparam int GAP_CYCLES = PERIOD_CYCLES - PULSE_CYCLES;

  // Refuse counts that the counters or the timing cannot serve.
  if (STROBE_CYCLES < 1 || STROBE_CYCLES > 2**CNT_W ||
      PERIOD_CYCLES <= PULSE_CYCLES || PERIOD_CYCLES > 2**CNT_W)
  begin : g_bad_count
    $error("Strobe or period count out of range.");
  end

  // Transmitter states.
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_PULSE, ST_GAP, ST_TRAIL} state_t;

  state_t                state;       // Current step of the frame.
  state_t                next_state;  // Next step of the frame.
  logic [CNT_W-1:0]      cnt;         // Cycles left in the current step.
  logic [CNT_W-1:0]      next_cnt;    // Next cycle count.
  logic [FRAME_W-1:0]    shift;       // Frame, next bit in the top position.
  logic [FRAME_W-1:0]    next_shift;  // Next frame shifter value.
  logic [LEFT_W-1:0]     left;        // Bits still to send, current one included.
  logic [LEFT_W-1:0]     next_left;   // Next bit count.
  logic                  strobe_on;   // Strobe used for the frame in flight.
  logic                  next_strobe_on;
  link_t                 next_oe;     // Next line drive enables.
  link_t                 line_meta;   // First synchroniser stage.
  link_t                 line_sync;   // Second synchroniser stage.
  logic                  lines_idle;  // All link lines read high.
  logic                  accept;      // Card data taken this cycle.

  // Builds the left-justified frame for the selected protocol.
  function automatic logic [FRAME_W-1:0] build_frame(input proto_t p, input card_t c);
    logic [W26_LEN-1:0] f26;
    logic [FRAME_W-1:0] f;
    f26 = {1'b0, c.facility[W26_FAC_W-1:0], c.user, 1'b0};
    f26[W26_LEN-1] = ^f26[24:13];
    f26[0] = ~^f26[12:1];
    if (p == PROTO_W33)
    begin
      f = {c.facility, c.user, ~^{c.facility, c.user}};
    end
    else
    begin
      f = {f26, {W26_PAD{1'b0}}};
    end
    return f;
  endfunction : build_frame

  // Pin levels pass two flip-flops before anything reads them.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      line_meta <= '1;
      line_sync <= '1;
    end
    else
    begin
      line_meta <= link_in;
      line_sync <= line_meta;
    end
  end

  // A frame starts only when no party holds a line low.
  assign lines_idle = &line_sync;
  assign card_ready = (state == ST_IDLE) && lines_idle;
  assign accept     = card_valid && card_ready;

  // The lines are only ever pulled low; release leaves them to the pull-ups.
  assign link_out = '0;

  // Next-state logic for the frame sequencer and the line drives.
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_shift     = shift;
    next_left      = left;
    next_strobe_on = strobe_on;
    if (cnt != '0)
    begin
      next_cnt = cnt - 1'b1;
    end
    unique case (state)
      ST_IDLE:
      begin
        // Data taken with no protocol selected is dropped silently.
        if (accept && cfg.proto != PROTO_NONE)
        begin
          next_shift     = build_frame(cfg.proto, card);
          next_left      = (cfg.proto == PROTO_W33) ? LEFT_W'(W33_LEN) : LEFT_W'(W26_LEN);
          next_strobe_on = cfg.strobe_en;
          if (cfg.strobe_en)
          begin
            next_state = ST_LEAD;
            next_cnt   = CNT_W'(STROBE_CYCLES - 1);
          end
          else
          begin
            next_state = ST_PULSE;
            next_cnt   = CNT_W'(PULSE_CYCLES - 1);
          end
        end
      end
      ST_LEAD:
      begin
        // The lead gap ends with the first bit pulse.
        if (cnt == '0)
        begin
          next_state = ST_PULSE;
          next_cnt   = CNT_W'(PULSE_CYCLES - 1);
        end
      end
      ST_PULSE:
      begin
        // After the last pulse of a strobed frame the trail gap follows directly.
        if (cnt == '0)
        begin
          if (left == LEFT_W'(1) && strobe_on)
          begin
            next_state = ST_TRAIL;
            next_cnt   = CNT_W'(STROBE_CYCLES - 1);
          end
          else
          begin
            next_state = ST_GAP;
            next_cnt   = CNT_W'(GAP_CYCLES - 1);
          end
        end
      end
      ST_GAP:
      begin
        // Idle gap keeps the start-to-start spacing even after a frame sent without strobe.
        if (cnt == '0)
        begin
          if (left == LEFT_W'(1))
          begin
            next_state = ST_IDLE;
          end
          else
          begin
            next_state = ST_PULSE;
            next_cnt   = CNT_W'(PULSE_CYCLES - 1);
            next_shift = shift << 1;
            next_left  = left - 1'b1;
          end
        end
      end
      ST_TRAIL:
      begin
        // The strobe is released when the trail gap runs out.
        if (cnt == '0)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    // Drives follow the next state so they line up with the state register.
    next_oe.zero_line        = (next_state == ST_PULSE) && !next_shift[FRAME_W-1];
    next_oe.one_bit_line     = (next_state == ST_PULSE) && next_shift[FRAME_W-1];
    next_oe.card_load_strobe = next_strobe_on && (next_state != ST_IDLE);
  end

  // Registers of the frame sequencer and the line drives.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      cnt       <= '0;
      shift     <= '0;
      left      <= '0;
      strobe_on <= 1'b0;
      link_oe   <= '0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      shift     <= next_shift;
      left      <= next_left;
      strobe_on <= next_strobe_on;
      link_oe   <= next_oe;
    end
  end

  // Cycles spent in the current state, read only by the checks below.
  logic [CNT_W:0] dwell;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dwell <= '0;
    end
    else
    begin
      dwell <= (next_state != state) ? '0 : dwell + 1'b1;
    end
  end

  // A frame start with the given protocol.
  sequence s_start(proto_t p);
    accept && cfg.proto == p;
  endsequence

  // The last cycle of a state.
  sequence s_leave(state_t s);
    state == s && next_state != s;
  endsequence

  a_silent_off: assert property (@(posedge ref_clk) disable iff (rst)
    s_start(PROTO_NONE) |=> state == ST_IDLE && link_oe == '0)
    else $error("Output driven with no protocol selected.");

  // A pulled zero line carries a low level, and no new frame is offered meanwhile.
  a_active_low: assert property (@(posedge ref_clk) disable iff (rst)
    link_oe.zero_line |-> !link_out.zero_line && !card_ready)
    else $error("Asserted line not driven low.");

  a_lead_time: assert property (@(posedge ref_clk) disable iff (rst)
    s_leave(ST_LEAD) |-> dwell == STROBE_CYCLES - 1 ##1 (link_oe.zero_line || link_oe.one_bit_line))
    else $error("Strobe lead time wrong.");

  a_trail_time: assert property (@(posedge ref_clk) disable iff (rst)
    s_leave(ST_TRAIL) |-> dwell == STROBE_CYCLES - 1 && link_oe.card_load_strobe
      ##1 !link_oe.card_load_strobe)
    else $error("Strobe trail time wrong.");

  a_pulse_width: assert property (@(posedge ref_clk) disable iff (rst)
    s_leave(ST_PULSE) |-> dwell == PULSE_CYCLES - 1 ##1 !(link_oe.zero_line || link_oe.one_bit_line))
    else $error("Bit pulse width wrong.");

  a_gap_time: assert property (@(posedge ref_clk) disable iff (rst)
    s_leave(ST_GAP) |-> dwell == GAP_CYCLES - 1)
    else $error("Idle time between bits wrong.");

  a_w26_fields: assert property (@(posedge ref_clk) disable iff (rst)
    s_start(PROTO_W26) |=> shift[31:24] == $past(card.facility[7:0]) && left == LEFT_W'(W26_LEN))
    else $error("26-bit facility field wrong.");

  a_w26_user: assert property (@(posedge ref_clk) disable iff (rst)
    s_start(PROTO_W26) |=> shift[23:8] == $past(card.user) && shift[6:0] == '0)
    else $error("26-bit user field wrong.");

  a_w26_even: assert property (@(posedge ref_clk) disable iff (rst)
    s_start(PROTO_W26) |=> (^shift[32:20]) == 1'b0)
    else $error("26-bit leading parity wrong.");

  a_w26_odd: assert property (@(posedge ref_clk) disable iff (rst)
    s_start(PROTO_W26) |=> (^shift[19:7]) == 1'b1)
    else $error("26-bit trailing parity wrong.");

  a_w33_fields: assert property (@(posedge ref_clk) disable iff (rst)
    s_start(PROTO_W33) |=> shift[32:17] == $past(card.facility) && shift[16:1] == $past(card.user))
    else $error("33-bit fields wrong.");

  a_w33_parity: assert property (@(posedge ref_clk) disable iff (rst)
    s_start(PROTO_W33) |=> (^shift) == 1'b1 && left == LEFT_W'(W33_LEN))
    else $error("33-bit parity wrong.");

  a_one_line: assert property (@(posedge ref_clk) disable iff (rst)
    !(link_oe.zero_line && link_oe.one_bit_line))
    else $error("Both data lines driven at once.");

  a_bit_value: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_PULSE |-> link_oe.one_bit_line == shift[FRAME_W-1])
    else $error("Pulse on the wrong data line.");

  a_no_strobe: assert property (@(posedge ref_clk) disable iff (rst)
    accept && cfg.proto != PROTO_NONE && !cfg.strobe_en
      |=> state == ST_PULSE && !link_oe.card_load_strobe)
    else $error("Strobe or lead gap used while disabled.");

endmodule : wiegand_card_data_transmitter

// ==== wiegand_rx_model.sv ====
// Model of the far-side controller input: pull-ups on the three link lines and a frame catcher.
// Assumes the transmitter's open-drain enables and the shared ref_clk.
`timescale 1ns/10ps
module wiegand_rx_model
  import wiegand_tx_pkg::*;
(
  // Clock, capture restart and a commanded jam of the zero line.
  input  wire logic   ref_clk,
  input  wire logic   clr,
  input  wire logic   jam,
  // Transmitter enables in, resolved wire levels out.
  input  wire link_t  oe,
  output link_t       lvl,
  // Captured frame and its timing in clock cycles.
  output logic [63:0] bits,
  output int          nbits,
  output int          nstrobe,
  output int          pw_min,
  output int          pw_max,
  output int          pp_min,
  output int          pp_max,
  output int          lead,
  output int          trail,
  output logic        both_low
);
  int    now;     // Free-running cycle count.
  int    fall_t;  // Time of the latest data pulse start.
  int    rise_t;  // Time of the latest data pulse end.
  int    sfall_t; // Time the strobe was asserted.
  link_t prev;    // Line levels one cycle earlier.

  // A line goes low only when someone pulls it; otherwise the pull-up wins.
  assign lvl = link_t'(~oe & {~jam, 2'b11});

  // Low is asserted; each falling edge is one bit, the line that fell gives its value.
  always @(posedge ref_clk)
  begin
    now <= now + 1;
    prev <= lvl;
    if (clr)
    begin
      now <= 0;
      bits <= '0;
      nbits <= 0;
      nstrobe <= 0;
      pw_min <= 32'h7FFFFFFF;
      pw_max <= 0;
      pp_min <= 32'h7FFFFFFF;
      pp_max <= 0;
      both_low <= 1'b0;
    end
    else
    begin
      if (!lvl.zero_line && !lvl.one_bit_line)
        both_low <= 1'b1;
      if ((prev.zero_line && !lvl.zero_line) || (prev.one_bit_line && !lvl.one_bit_line))
      begin
        bits <= {bits[62:0], lvl.zero_line};
        nbits <= nbits + 1;
        fall_t <= now;
        if (nbits == 0)
          lead <= now - sfall_t;
        else
        begin
          pp_min <= (now - fall_t < pp_min) ? now - fall_t : pp_min;
          pp_max <= (now - fall_t > pp_max) ? now - fall_t : pp_max;
        end
      end
      if ((!prev.zero_line && lvl.zero_line) || (!prev.one_bit_line && lvl.one_bit_line))
      begin
        rise_t <= now;
        pw_min <= (now - fall_t < pw_min) ? now - fall_t : pw_min;
        pw_max <= (now - fall_t > pw_max) ? now - fall_t : pw_max;
      end
      if (prev.card_load_strobe && !lvl.card_load_strobe)
      begin
        sfall_t <= now;
        nstrobe <= nstrobe + 1;
      end
      if (!prev.card_load_strobe && lvl.card_load_strobe)
        trail <= now - rise_t;
    end
  end
endmodule : wiegand_rx_model

// ==== tb_top.sv ====
// Self-checking bench for the card data transmitter with shortened gaps and period.
// Assumes the far-side model resolves the open-drain lines.
`timescale 1ns/10ps
module tb_top
  import wiegand_tx_pkg::*;
;
  localparam int STRB = 20;   // Shortened strobe gap in cycles.
  localparam int PER  = 1100; // Shortened bit period in cycles.
  logic        ref_clk, rst, card_valid, card_ready, clr, jam, both_low;
  cfg_t        cfg;
  card_t       card;
  link_t       link_out, link_oe, lvl;
  logic [63:0] bits;
  int          nbits, nstrobe, pw_min, pw_max, pp_min, pp_max, lead, trail;
  int          miscompares, n_compared;

  wiegand_card_data_transmitter #(.STROBE_CYCLES(STRB), .PERIOD_CYCLES(PER))
    wiegand_card_data_transmitter_i (.ref_clk(ref_clk), .rst(rst), .cfg(cfg),
    .card_valid(card_valid), .card(card), .card_ready(card_ready), .link_in(lvl),
    .link_out(link_out), .link_oe(link_oe));

  wiegand_rx_model wiegand_rx_model_i (.ref_clk(ref_clk), .clr(clr), .jam(jam), .oe(link_oe),
    .lvl(lvl), .bits(bits), .nbits(nbits), .nstrobe(nstrobe), .pw_min(pw_min), .pw_max(pw_max),
    .pp_min(pp_min), .pp_max(pp_max), .lead(lead), .trail(trail), .both_low(both_low));

  // Compares one value and reports a difference at once.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // Waits at falling edges for ready, bounded; a timeout counts as a mismatch.
  task automatic wait_ready(input int lim);
    for (int i = 0; i < lim && card_ready !== 1'b1; i++)
      @(negedge ref_clk);
    if (card_ready !== 1'b1)
      miscompares++;
  endtask : wait_ready

  // Offers one card, lets the frame run out and judges the captured frame.
  task automatic frame(input proto_t p, input logic se, input logic [15:0] f,
                       input logic [15:0] u, input logic [63:0] exp, input int n);
    @(negedge ref_clk);
    clr = 1'b1;
    @(negedge ref_clk);
    clr = 1'b0;
    cfg = '{p, se};
    card = '{f, u};
    card_valid = 1'b1;
    wait_ready(5);
    @(negedge ref_clk);
    card_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    wait_ready(45000);
    check(64'(nbits), 64'(n));
    check(bits, exp);
    check(64'(both_low), 64'h0);
    check(64'(nstrobe), {63'h0, se});
    check(64'(pw_min), 64'(PULSE_CYCLES));
    check(64'(pw_max), 64'(PULSE_CYCLES));
    check(64'(pp_min), 64'(PER));
    check(64'(pp_max), 64'(PER));
    if (se)
    begin
      check(64'(lead), 64'(STRB));
      check(64'(trail), 64'(STRB));
    end
  endtask : frame

  // A jammed line holds off the start; an unselected protocol then emits nothing.
  task automatic t_guard_none;
    @(negedge ref_clk);
    jam = 1'b1;
    repeat (3) @(negedge ref_clk);
    cfg = '{PROTO_NONE, 1'b1};
    card = '{16'h1234, 16'h5678};
    card_valid = 1'b1;
    repeat (50) @(negedge ref_clk);
    check(64'(card_ready), 64'h0);
    // The jam itself made an edge on the zero line; clear the catcher over its release.
    jam = 1'b0;
    clr = 1'b1;
    wait_ready(10);
    @(negedge ref_clk);
    card_valid = 1'b0;
    clr = 1'b0;
    repeat (200) @(negedge ref_clk);
    check(64'(nbits), 64'h0);
    check(64'(nstrobe), 64'h0);
    check(64'(link_out), 64'h0);
  endtask : t_guard_none

  // Short format with strobe and a facility above 255, so truncation shows.
  task automatic t_w26_strobe;
    logic [15:0] f;
    logic [15:0] u;
    f = 16'hA5C3;
    u = 16'h9E17;
    frame(PROTO_W26, 1'b1, f, u,
          {38'h0, ^{f[7:0], u[15:12]}, f[7:0], u, ~^u[11:0]}, 26);
  endtask : t_w26_strobe

  // Long format without strobe, with boundary bit patterns in both fields.
  task automatic t_w33_plain;
    logic [15:0] f;
    logic [15:0] u;
    f = 16'h8001;
    u = 16'h7FFE;
    frame(PROTO_W33, 1'b0, f, u, {31'h0, f, u, ~^{f, u}}, 33);
  endtask : t_w33_plain

  // Free-running reference clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    card_valid = 1'b0;
    cfg = '{PROTO_NONE, 1'b0};
    card = '0;
    clr = 1'b1;
    jam = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    clr = 1'b0;
    check(64'(link_oe), 64'h0);
    t_guard_none();
    t_w26_strobe();
    t_w33_plain();
    finish_test();
  end

  // Watchdog well beyond the expected run of about 65000 cycles.
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
endmodule : tb_top
